// ==== core/stmr_top.sv ====
// Standard timer: 16-bit counter, two comparators, waveform output, APB slave
// Functional notes
// - 16-bit up-counter clocked from a chosen internal clock or external pin edge.
// - Period comparator matches upper counter byte; compare A matches all sixteen bits.
// - Software changes the counter only by a rising edge of timer_on.
// - Counter clears on overflow or selected match, raising a match flag.
// - Pause bit holds the counter; clearing it resumes from the held value.
// - Clock select: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall.
// - Timer off holds counter; off-to-on clears counter before counting.
// - Off-to-on in output modes forces pin to level chosen by level control.
// - Mode field: compare output, undefined, PWM or single pulse, timer/counter.
// - Timer/counter mode: pin undefined, level control and invert ignored.
// - Compare mode on A match: no change, low, high or toggle.
// - PWM mode pin function: inactive, active, PWM wave, single pulse.
// - Compare match gives no visible change when requested level equals current.
// - Level control: initial level, PWM active level, or single-pulse start level.
// - Invert bit set inverts the output pin; clear passes it through.
// - Swap bit 0: period comparator sets period, A duty; 1 swaps.
// - Clear select 1 clears on A match, 0 on period match or overflow.
// - Clear select is ignored in PWM or single-pulse mode.
// - Low three bits of control register A read as zero.
// - Period value zero lets the counter overflow after 65536 clocks.
// - With compare A clearing, the period match flag is never raised.
//
// Decided for this implementation: the register addresses and register access over APB.
`include "stmr_defs.svh"
`default_nettype none
module stmr_top
   import stmr_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Clock sources, synchronous to MCLK
   input wire logic HIGH_CLK,
   input wire logic SUB_CLK,
   input wire logic EXT_CLOCK_PIN,
   // Waveform output and match flags
   output logic WAVEFORM_OUT_PIN,
   output logic COMPARE_A_MATCH_FLAG,
   output logic PERIOD_MATCH_FLAG
);
   stmr_state_t r_ff, nxt_r;

   function automatic logic [31:0] rd_mux(input stmr_state_t s, input logic [11:0] a);
      case (a)
         `STMR_OFF_CTRL_A: rd_mux = {24'h000000, s.ctrl_a[7:3], 3'h0};
         `STMR_OFF_CTRL_B: rd_mux = {24'h000000, s.ctrl_b};
         `STMR_OFF_CNT_LO: rd_mux = {24'h000000, s.cnt[7:0]};
         `STMR_OFF_CNT_HI: rd_mux = {24'h000000, s.cnt[15:8]};
         `STMR_OFF_CMPA_LO: rd_mux = {24'h000000, s.cmpa[7:0]};
         `STMR_OFF_CMPA_HI: rd_mux = {24'h000000, s.cmpa[15:8]};
         `STMR_OFF_PERIOD: rd_mux = {24'h000000, s.period};
         `STMR_OFF_STATUS: rd_mux = {30'h00000000, s.flag_p, s.flag_a};
         default: rd_mux = 32'h00000000;
      endcase
   endfunction : rd_mux

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a[11:5] == 7'h00) && (a[1:0] == 2'h0);
   endfunction : addr_ok

   logic acc, wr, on_rise, tick, match_a, match_p, ovf, clr, mode_pwm;
   logic clr_by_a, duty_on, dut_a, per_p;
   logic [1:0] pinf;
   logic [7:0] wb;

   always_comb begin
      nxt_r = r_ff;
      acc = PSEL && PENABLE && r_ff.pready;
      wr = acc && PWRITE;
      wb = PWDATA[7:0];
      nxt_r.pready = PSEL && !r_ff.pready;
      nxt_r.pslverr = 1'b0;
      if (PSEL && !r_ff.pready) begin
         nxt_r.prdata = rd_mux(r_ff, PADDR);
         nxt_r.pslverr = !addr_ok(PADDR);
      end
      if (wr) begin
         case (PADDR)
            `STMR_OFF_CTRL_A: nxt_r.ctrl_a = {wb[7:3], 3'h0};
            `STMR_OFF_CTRL_B: nxt_r.ctrl_b = wb;
            `STMR_OFF_CMPA_LO: nxt_r.cmpa[7:0] = wb;
            `STMR_OFF_CMPA_HI: nxt_r.cmpa[15:8] = wb;
            `STMR_OFF_PERIOD: nxt_r.period = wb;
            // Write one to clear match flags
            `STMR_OFF_STATUS: begin
               if (wb[0]) nxt_r.flag_a = 1'b0;
               if (wb[1]) nxt_r.flag_p = 1'b0;
            end
            default: ;
         endcase
      end
      on_rise = !r_ff.ctrl_a[`STMR_A_ON] && nxt_r.ctrl_a[`STMR_A_ON];
      nxt_r.h_d = HIGH_CLK;
      nxt_r.sub_d = SUB_CLK;
      nxt_r.ext_d = EXT_CLOCK_PIN;
      nxt_r.div = r_ff.div + 6'h01;
      case (stmr_cksel_t'(r_ff.ctrl_a[6:4]))
         STMR_CK_SYS4: tick = (r_ff.div[1:0] == 2'h3);
         STMR_CK_SYS: tick = 1'b1;
         STMR_CK_H16: tick = HIGH_CLK && !r_ff.h_d && (r_ff.div[3:0] == 4'hF);
         STMR_CK_H64: tick = HIGH_CLK && !r_ff.h_d && (r_ff.div == 6'h3F);
         STMR_CK_SUB0, STMR_CK_SUB1: tick = SUB_CLK && !r_ff.sub_d;
         STMR_CK_EXTR: tick = EXT_CLOCK_PIN && !r_ff.ext_d;
         STMR_CK_EXTF: tick = !EXT_CLOCK_PIN && r_ff.ext_d;
         default: tick = 1'b0;
      endcase
      // High clock divider only advances on high-clock edges
      if (r_ff.ctrl_a[6:4] == 3'b010 || r_ff.ctrl_a[6:4] == 3'b011)
         nxt_r.div = (HIGH_CLK && !r_ff.h_d) ? r_ff.div + 6'h01 : r_ff.div;
      // pause and off hold the count
      tick = tick && r_ff.ctrl_a[`STMR_A_ON] && !r_ff.ctrl_a[`STMR_A_PAUSE];
      mode_pwm = r_ff.ctrl_b[7:6] == STMR_MODE_PWM;
      pinf = r_ff.ctrl_b[5:4];
      match_a = tick && (r_ff.cnt + 16'h0001 == r_ff.cmpa) && (r_ff.cmpa != 16'h0000);
      match_p = tick && (r_ff.period != 8'h00) && (r_ff.cnt[7:0] == 8'hFF)
         && (r_ff.cnt[15:8] + 8'h01 == r_ff.period);
      // zero period runs to full overflow
      ovf = tick && (r_ff.cnt == 16'hFFFF);
      // in PWM the swap bit picks which comparator clears
      if (mode_pwm) clr_by_a = r_ff.ctrl_b[`STMR_B_DPX];
      else clr_by_a = r_ff.ctrl_b[`STMR_B_CCLR];
      clr = clr_by_a ? match_a : (match_p || (ovf && r_ff.period == 8'h00));
      if (tick) nxt_r.cnt = clr ? 16'h0000 : r_ff.cnt + 16'h0001;
      // period flag suppressed under A clearing
      if (match_a) nxt_r.flag_a = 1'b1;
      if (match_p && !clr_by_a) nxt_r.flag_p = 1'b1;
      if (ovf && r_ff.period == 8'h00 && !clr_by_a) nxt_r.flag_p = 1'b1;
      // Duty compare on the reload-following count
      dut_a = !r_ff.ctrl_b[`STMR_B_DPX];
      per_p = (r_ff.period == 8'h00) ? 1'b1 : (r_ff.cnt[15:8] < r_ff.period);
      duty_on = dut_a ? (r_ff.cnt < r_ff.cmpa || !per_p)
         : ((r_ff.period == 8'h00) || (r_ff.cnt[15:8] < r_ff.period));
      if (r_ff.ctrl_b[7:6] == STMR_MODE_CMP && match_a) begin
         case (pinf)
            2'b01: nxt_r.out_raw = 1'b0;
            2'b10: nxt_r.out_raw = 1'b1;
            2'b11: nxt_r.out_raw = !r_ff.out_raw;
            default: ;
         endcase
      end
      if (mode_pwm) begin
         case (pinf)
            2'b00: nxt_r.out_raw = !r_ff.ctrl_b[`STMR_B_OC];
            2'b01: nxt_r.out_raw = r_ff.ctrl_b[`STMR_B_OC];
            2'b10: nxt_r.out_raw = (duty_on && r_ff.ctrl_a[`STMR_A_ON])
               ? r_ff.ctrl_b[`STMR_B_OC] : !r_ff.ctrl_b[`STMR_B_OC];
            default: begin
               case (r_ff.sp)
                  STMR_SP_PULSE: if (match_a || clr) begin
                     nxt_r.sp = STMR_SP_DONE;
                     nxt_r.out_raw = !r_ff.ctrl_b[`STMR_B_OC];
                  end
                  STMR_SP_IDLE, STMR_SP_DONE: ;
                  default: nxt_r.sp = STMR_SP_IDLE;
               endcase
            end
         endcase
      end
      if (on_rise) begin
         nxt_r.cnt = 16'h0000;
         if (nxt_r.ctrl_b[7:6] != STMR_MODE_TMR) nxt_r.out_raw = nxt_r.ctrl_b[`STMR_B_OC];
         nxt_r.sp = STMR_SP_PULSE;
      end
      if (nxt_r.ctrl_b[7:6] == STMR_MODE_TMR) nxt_r.pin = 1'b0;
      else nxt_r.pin = nxt_r.out_raw ^ nxt_r.ctrl_b[`STMR_B_POL];
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign PRDATA = r_ff.prdata;
   assign PREADY = r_ff.pready;
   assign PSLVERR = r_ff.pslverr;
   assign WAVEFORM_OUT_PIN = r_ff.pin;
   assign COMPARE_A_MATCH_FLAG = r_ff.flag_a;
   assign PERIOD_MATCH_FLAG = r_ff.flag_p;

   sequence s_on_rise;
      !r_ff.ctrl_a[`STMR_A_ON] ##1 r_ff.ctrl_a[`STMR_A_ON];
   endsequence
   property p_on_clear;
      @(posedge MCLK) disable iff (RST) s_on_rise |-> r_ff.cnt <= 16'h0001;
   endproperty
   a_on_clear: assert property (p_on_clear) else $error("counter not cleared on enable");
   property p_pause_hold;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_a[`STMR_A_PAUSE] && $past(r_ff.ctrl_a[`STMR_A_PAUSE])
         && !$rose(r_ff.ctrl_a[`STMR_A_ON]) |-> $stable(r_ff.cnt);
   endproperty
   a_pause_hold: assert property (p_pause_hold) else $error("counter moved in pause");
   property p_off_hold;
      @(posedge MCLK) disable iff (RST)
         !r_ff.ctrl_a[`STMR_A_ON] && !$past(r_ff.ctrl_a[`STMR_A_ON]) |-> $stable(r_ff.cnt);
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("counter moved while off");
   property p_low_zero;
      @(posedge MCLK) disable iff (RST) r_ff.ctrl_a[2:0] == 3'h0;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("reserved bits set");
   property p_no_pflag;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_b[7:6] != STMR_MODE_PWM && r_ff.ctrl_b[`STMR_B_CCLR] && !r_ff.flag_p
         |=> !r_ff.flag_p;
   endproperty
   a_no_pflag: assert property (p_no_pflag) else $error("period flag under A clear");
   property p_a_clear;
      @(posedge MCLK) disable iff (RST)
         match_a && clr_by_a && !on_rise |=> r_ff.cnt == 16'h0000 && r_ff.flag_a;
   endproperty
   a_a_clear: assert property (p_a_clear) else $error("A match did not clear");
   property p_tmr_pin;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_b[7:6] == STMR_MODE_TMR |-> !WAVEFORM_OUT_PIN;
   endproperty
   a_tmr_pin: assert property (p_tmr_pin) else $error("pin active in timer mode");
   property p_pol;
      @(posedge MCLK) disable iff (RST) r_ff.ctrl_b[7:6] != STMR_MODE_TMR
         |-> WAVEFORM_OUT_PIN == (r_ff.out_raw ^ r_ff.ctrl_b[`STMR_B_POL]);
   endproperty
   a_pol: assert property (p_pol) else $error("output inversion wrong");

   // Checks below look at the state one edge after the comb decision
   sequence s_cmp_hit;
      r_ff.ctrl_b[7:6] == STMR_MODE_CMP && match_a && !on_rise;
   endsequence
   sequence s_pwm_hold;
      mode_pwm && !on_rise;
   endsequence

   property p_sys_count;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_a[6:4] == 3'b001 && r_ff.ctrl_a[`STMR_A_ON] && !r_ff.ctrl_a[`STMR_A_PAUSE]
         && !clr |=> r_ff.cnt == $past(r_ff.cnt) + 16'h0001;
   endproperty
   a_sys_count: assert property (p_sys_count) else $error("no system tick");

   property p_ext_rise;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_a[6:4] == 3'b110 && r_ff.ctrl_a[`STMR_A_ON] && !r_ff.ctrl_a[`STMR_A_PAUSE]
         && $rose(EXT_CLOCK_PIN) && !clr |=> r_ff.cnt == $past(r_ff.cnt) + 16'h0001;
   endproperty
   a_ext_rise: assert property (p_ext_rise) else $error("rising edge not counted");

   property p_ext_fall;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_a[6:4] == 3'b111 && r_ff.ctrl_a[`STMR_A_ON] && !r_ff.ctrl_a[`STMR_A_PAUSE]
         && $fell(EXT_CLOCK_PIN) && !clr |=> r_ff.cnt == $past(r_ff.cnt) + 16'h0001;
   endproperty
   a_ext_fall: assert property (p_ext_fall) else $error("falling edge not counted");

   property p_ext_quiet;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_a[6:4] == 3'b110 && $stable(EXT_CLOCK_PIN) && !on_rise |=> $stable(r_ff.cnt);
   endproperty
   a_ext_quiet: assert property (p_ext_quiet) else $error("count without pin edge");

   property p_p_clear;
      @(posedge MCLK) disable iff (RST)
         match_p && !clr_by_a && !on_rise |=> r_ff.cnt == 16'h0000 && r_ff.flag_p;
   endproperty
   a_p_clear: assert property (p_p_clear) else $error("period match did not clear");

   property p_ovf_wrap;
      @(posedge MCLK) disable iff (RST)
         ovf && r_ff.period == 8'h00 && !clr_by_a && !on_rise
         |=> r_ff.cnt == 16'h0000 && r_ff.flag_p;
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow not flagged");

   property p_on_level;
      @(posedge MCLK) disable iff (RST)
         s_on_rise |-> r_ff.ctrl_b[7:6] == STMR_MODE_TMR
         || r_ff.out_raw == r_ff.ctrl_b[`STMR_B_OC];
   endproperty
   a_on_level: assert property (p_on_level) else $error("initial level not set");

   property p_cmp_toggle;
      @(posedge MCLK) disable iff (RST)
         s_cmp_hit ##0 (pinf == 2'b11) |=> r_ff.out_raw != $past(r_ff.out_raw);
   endproperty
   a_cmp_toggle: assert property (p_cmp_toggle) else $error("no toggle on match");

   property p_cmp_high;
      @(posedge MCLK) disable iff (RST)
         s_cmp_hit ##0 (pinf == 2'b10) |=> r_ff.out_raw;
   endproperty
   a_cmp_high: assert property (p_cmp_high) else $error("match did not drive high");

   property p_cmp_low;
      @(posedge MCLK) disable iff (RST)
         s_cmp_hit ##0 (pinf == 2'b01) |=> !r_ff.out_raw;
   endproperty
   a_cmp_low: assert property (p_cmp_low) else $error("match did not drive low");

   property p_cmp_hold;
      @(posedge MCLK) disable iff (RST)
         r_ff.ctrl_b[7:6] == STMR_MODE_CMP && pinf == 2'b00 && !on_rise
         |=> $stable(r_ff.out_raw);
   endproperty
   a_cmp_hold: assert property (p_cmp_hold) else $error("pin moved with no action");

   property p_pwm_inact;
      @(posedge MCLK) disable iff (RST)
         s_pwm_hold ##0 (pinf == 2'b00) |=> r_ff.out_raw != $past(r_ff.ctrl_b[`STMR_B_OC]);
   endproperty
   a_pwm_inact: assert property (p_pwm_inact) else $error("pin not inactive");

   property p_pwm_act;
      @(posedge MCLK) disable iff (RST)
         s_pwm_hold ##0 (pinf == 2'b01) |=> r_ff.out_raw == $past(r_ff.ctrl_b[`STMR_B_OC]);
   endproperty
   a_pwm_act: assert property (p_pwm_act) else $error("pin not active");

   property p_pwm_noclr;
      @(posedge MCLK) disable iff (RST)
         s_pwm_hold ##0 (!r_ff.ctrl_b[`STMR_B_DPX] && match_a && !match_p && !ovf)
         |=> r_ff.cnt == $past(r_ff.cmpa);
   endproperty
   a_pwm_noclr: assert property (p_pwm_noclr) else $error("duty match cleared");

   property p_sp_end;
      @(posedge MCLK) disable iff (RST)
         s_pwm_hold ##0 (pinf == 2'b11 && r_ff.sp == STMR_SP_PULSE && match_a)
         |=> r_ff.sp == STMR_SP_DONE && r_ff.out_raw != $past(r_ff.ctrl_b[`STMR_B_OC]);
   endproperty
   a_sp_end: assert property (p_sp_end) else $error("single pulse did not end");
endmodule : stmr_top
`default_nettype wire

// ==== core/stmr_defs.svh ====
// Register offsets, field positions and reset values of the standard timer
`ifndef STMR_DEFS_SVH
`define STMR_DEFS_SVH
`define STMR_OFF_CTRL_A 12'h000
`define STMR_OFF_CTRL_B 12'h004
`define STMR_OFF_CNT_LO 12'h008
`define STMR_OFF_CNT_HI 12'h00C
`define STMR_OFF_CMPA_LO 12'h010
`define STMR_OFF_CMPA_HI 12'h014
`define STMR_OFF_PERIOD 12'h018
`define STMR_OFF_STATUS 12'h01C
`define STMR_A_PAUSE 7
`define STMR_A_CKSEL_LSB 4
`define STMR_A_ON 3
`define STMR_B_MODE_LSB 6
`define STMR_B_PINF_LSB 4
`define STMR_B_OC 3
`define STMR_B_POL 2
`define STMR_B_DPX 1
`define STMR_B_CCLR 0
`define STMR_CTRL_A_RST 8'h00
`define STMR_CTRL_B_RST 8'h00
`define STMR_CMPA_RST 16'h0000
`define STMR_PERIOD_RST 8'h00
`define STMR_DIV_SYS4 4
`define STMR_DIV_H16 16
`define STMR_DIV_H64 64
`endif

// ==== core/stmr_pkg.sv ====
// Types of the standard timer
`default_nettype none
package stmr_pkg;
   typedef enum logic [1:0] {
      STMR_MODE_CMP = 2'b00, STMR_MODE_UNDEF = 2'b01,
      STMR_MODE_PWM = 2'b10, STMR_MODE_TMR = 2'b11
   } stmr_mode_t;
   typedef enum logic [2:0] {
      STMR_CK_SYS4 = 3'b000, STMR_CK_SYS = 3'b001, STMR_CK_H16 = 3'b010,
      STMR_CK_H64 = 3'b011, STMR_CK_SUB0 = 3'b100, STMR_CK_SUB1 = 3'b101,
      STMR_CK_EXTR = 3'b110, STMR_CK_EXTF = 3'b111
   } stmr_cksel_t;
   // Gray-coded single-pulse sequence
   typedef enum logic [1:0] {
      STMR_SP_IDLE = 2'b00, STMR_SP_PULSE = 2'b01, STMR_SP_DONE = 2'b11
   } stmr_sp_t;
   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [15:0] cmpa;
      logic [7:0] period;
      logic [15:0] cnt;
      logic [5:0] div;
      logic h_d;
      logic sub_d;
      logic ext_d;
      logic out_raw;
      stmr_sp_t sp;
      logic flag_a;
      logic flag_p;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic pin;
   } stmr_state_t;
endpackage : stmr_pkg
`default_nettype wire

// ==== verification/stmr_pin_model.sv ====
// Far-side model: clock source pins feeding the standard timer
`default_nettype none
module stmr_pin_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Clock pins
   output logic high_clk,
   output logic sub_clk,
   output var logic ext_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_ff;
   // Internal oscillators run free; only the external pin stands still
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_ff <= 3'h0;
      end else begin
         div_ff <= div_ff + 3'h1;
      end
   end
   assign high_clk = div_ff[0];
   assign sub_clk = div_ff[2];
   initial begin
      ext_clk = 1'b0;
   end
   // Pulses are two cycles high, two low, so both edges are seen
   task automatic send(input int n);
      repeat (n) begin
         ext_clk <= 1'b1;
         repeat (2) @(posedge mclk);
         ext_clk <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask : send
endmodule : stmr_pin_model
`default_nettype wire

// ==== verification/stmr_top_tb_top.sv ====
// Self-checking testbench of the standard timer
`include "stmr_defs.svh"
`default_nettype none
module stmr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr;
   logic high_clk, sub_clk, ext_clk, wave, flag_a, flag_p, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int n_errors = 0;
   int n_checks = 0;
   stmr_top DUT (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .HIGH_CLK(high_clk), .SUB_CLK(sub_clk), .EXT_CLOCK_PIN(ext_clk),
      .WAVEFORM_OUT_PIN(wave), .COMPARE_A_MATCH_FLAG(flag_a), .PERIOD_MATCH_FLAG(flag_p));
   stmr_pin_model u_pins (.mclk(mclk), .rst(rst), .high_clk(high_clk), .sub_clk(sub_clk),
      .ext_clk(ext_clk));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string nm);
      apb(1'b0, a, 8'h00);
      chk(nm, rdat, {24'h0, e});
   endtask : rdc
   task automatic send(input int n);
      u_pins.send(n);
      cyc(4);
   endtask : send
   task automatic setup(input logic [7:0] b, input logic [7:0] a);
      wr(`STMR_OFF_CTRL_A, 8'h00);
      wr(`STMR_OFF_CTRL_B, b);
      wr(`STMR_OFF_STATUS, 8'h03);
      wr(`STMR_OFF_CTRL_A, a);
      cyc(2);
   endtask : setup
   task automatic s_reset();
      for (int i = 0; i < 7; i++) rdc(12'(i * 4), 8'h00, "reg_reset");
      apb(1'b0, 12'h020, 8'h00);
      chk("unmapped_err", {31'h0, rerr}, 32'h1);
      wr(`STMR_OFF_CTRL_A, 8'h07);
      rdc(`STMR_OFF_CTRL_A, 8'h00, "ctrl_a_low_bits");
      wr(`STMR_OFF_CTRL_B, 8'hA5);
      rdc(`STMR_OFF_CTRL_B, 8'hA5, "ctrl_b_rw");
   endtask : s_reset
   task automatic s_ext_clock();
      logic [7:0] ena;
      wr(`STMR_OFF_PERIOD, 8'h00);
      for (int s = 6; s < 8; s++) begin
         ena = {1'b0, 3'(s), 4'h8};
         setup(8'hC0, ena);
         rdc(`STMR_OFF_CNT_LO, 8'h00, "cnt_after_on");
         send(10);
         rdc(`STMR_OFF_CNT_LO, 8'h0A, "cnt_ext_edges");
         wr(`STMR_OFF_CTRL_A, ena | 8'h80);
         send(4);
         rdc(`STMR_OFF_CNT_LO, 8'h0A, "cnt_paused");
         wr(`STMR_OFF_CTRL_A, ena);
         send(2);
         rdc(`STMR_OFF_CNT_LO, 8'h0C, "cnt_resumed");
         wr(`STMR_OFF_CTRL_A, 8'h00);
         send(3);
         rdc(`STMR_OFF_CNT_LO, 8'h0C, "cnt_off_hold");
         rdc(`STMR_OFF_CNT_HI, 8'h00, "cnt_high");
      end
   endtask : s_ext_clock
   task automatic s_compare();
      wr(`STMR_OFF_CMPA_LO, 8'h03);
      wr(`STMR_OFF_CMPA_HI, 8'h00);
      setup(8'h31, 8'h68);
      chk("pin_initial", {31'h0, wave}, 32'h0);
      send(3);
      chk("pin_toggle", {31'h0, wave}, 32'h1);
      chk("flag_a", {31'h0, flag_a}, 32'h1);
      chk("flag_p_none", {31'h0, flag_p}, 32'h0);
      rdc(`STMR_OFF_CNT_LO, 8'h00, "cnt_cleared");
      send(3);
      chk("pin_toggle_back", {31'h0, wave}, 32'h0);
      setup(8'h29, 8'h68);
      chk("pin_init_high", {31'h0, wave}, 32'h1);
      send(3);
      chk("pin_same_level", {31'h0, wave}, 32'h1);
      setup(8'h2D, 8'h68);
      chk("pin_inverted", {31'h0, wave}, 32'h0);
      setup(8'h19, 8'h68);
      send(3);
      chk("pin_drive_low", {31'h0, wave}, 32'h0);
      setup(8'h09, 8'h68);
      send(3);
      chk("pin_no_change", {31'h0, wave}, 32'h1);
   endtask : s_compare
   task automatic s_clock_select();
      for (int s = 0; s < 6; s++) begin
         setup(8'hCC, {1'b0, 3'(s), 4'h8});
         cyc(300);
         apb(1'b0, `STMR_OFF_CNT_LO, 8'h00);
         chk("cnt_moves", {31'h0, rdat[7:0] !== 8'h00}, 32'h1);
         chk("pin_timer_mode", {31'h0, wave}, 32'h0);
      end
   endtask : s_clock_select
   task automatic s_period();
      wr(`STMR_OFF_CMPA_HI, 8'h10);
      wr(`STMR_OFF_PERIOD, 8'h01);
      setup(8'h00, 8'h18);
      cyc(300);
      chk("flag_p_match", {31'h0, flag_p}, 32'h1);
      chk("flag_a_full_width", {31'h0, flag_a}, 32'h0);
      rdc(`STMR_OFF_CNT_HI, 8'h00, "cnt_hi_period");
   endtask : s_period
   task automatic s_pwm();
      wr(`STMR_OFF_CMPA_LO, 8'h03);
      wr(`STMR_OFF_CMPA_HI, 8'h00);
      wr(`STMR_OFF_PERIOD, 8'h00);
      setup(8'hA9, 8'h68);
      chk("pwm_duty_start", {31'h0, wave}, 32'h1);
      send(3);
      chk("pwm_duty_end", {31'h0, wave}, 32'h0);
      chk("pwm_flag_a", {31'h0, flag_a}, 32'h1);
      rdc(`STMR_OFF_CNT_LO, 8'h03, "pwm_no_cclr");
      setup(8'h89, 8'h68);
      chk("pwm_inactive", {31'h0, wave}, 32'h0);
      setup(8'h99, 8'h68);
      chk("pwm_active", {31'h0, wave}, 32'h1);
      setup(8'hB9, 8'h68);
      chk("pulse_start", {31'h0, wave}, 32'h1);
      send(3);
      chk("pulse_end", {31'h0, wave}, 32'h0);
   endtask : s_pwm
   // Full 16-bit wrap takes 65536 system clocks
   task automatic s_overflow();
      wr(`STMR_OFF_PERIOD, 8'h00);
      setup(8'hC0, 8'h18);
      cyc(65500);
      chk("ovf_not_yet", {31'h0, flag_p}, 32'h0);
      cyc(40);
      chk("ovf_flag_p", {31'h0, flag_p}, 32'h1);
      rdc(`STMR_OFF_CNT_HI, 8'h00, "ovf_wrapped");
   endtask : s_overflow
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cyc(4);
      rst <= 1'b0;
      s_reset();
      s_ext_clock();
      s_compare();
      s_clock_select();
      s_period();
      s_pwm();
      s_overflow();
      report_and_stop();
   end
   // Whole run needs about 70000 cycles, mostly the overflow wait
   initial begin
      cyc(90000);
      n_errors++;
      report_and_stop();
   end
endmodule : stmr_top_tb_top
`default_nettype wire
